/* shared/ref_window_pkg.sv */
package ref_window_pkg;

   // ****************************************
   // widths and counts
   // ****************************************
   localparam int MAP_W = 24;
   localparam int SEL_W = 4;
   localparam int DLY_W = 8;
   localparam int TAD_W = 2 * DLY_W + 1;
   localparam int MIN_EDGES = 3;
   localparam int ADDR_W = 16;

   // ****************************************
   // register indices, byte address is four times the index
   // ****************************************
   localparam logic [11:0] IDX_CLK_CTRL = 12'h029;
   localparam logic [11:0] IDX_CAL_EN = 12'h02A;
   localparam logic [11:0] IDX_CAL_CFG = 12'h02B;
   localparam logic [11:0] IDX_POS_LOW = 12'h02C;
   localparam logic [11:0] IDX_POS_MID = 12'h02D;
   localparam logic [11:0] IDX_POS_HIGH = 12'h02E;
   localparam logic [11:0] IDX_CAL_STAT = 12'h02F;
   localparam logic [11:0] IDX_FOUND = 12'h030;
   localparam logic [11:0] IDX_TAD = 12'h031;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_ZOOM_BIT = 4;
   localparam int EN_BIT = 0;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_VALID_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int APERTURE_DELAY_FINE_LSB = 0;
   localparam int APERTURE_DELAY_COARSE_LSB = 8;
   localparam int APERTURE_CLOCK_INVERT_BIT = 16;
   localparam logic [SEL_W-1:0] SEL_RST = 4'h0;
   localparam logic ZOOM_RST = 1'b0;
   localparam logic [7:0] CFG_RST = 8'h04;
   localparam logic [TAD_W-1:0] TAD_RST = 17'h00000;

   // autocal sequencer states
   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_SETTLE,
      CAL_JUDGE,
      CAL_DONE
   } cal_state_t;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [11:0] idx);
      reg_addr = {2'h0, idx, 2'h0};
   endfunction : reg_addr

endpackage : ref_window_pkg

/* verilog/signal_sync.sv */
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser, first stage feeds only the second
module signal_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ****************************************
   // synchroniser stages
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

   initial begin
      if (W < 1) $error("signal_sync: W must be positive");
   end
endmodule : signal_sync

`default_nettype wire

/* verilog/ref_position_detector.sv */
`timescale 1ns/10ps
`default_nettype none

// builds the violation map from tap snapshots taken at each reference edge
module ref_position_detector
   import ref_window_pkg::*;
#(
   parameter int N = MAP_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // sampling
   input wire logic ref_rise,
   input wire logic restart,
   input wire logic [N-1:0] taps,
   // result
   output logic [N-1:0] map,
   output logic valid
);
   localparam int CW = $clog2(MIN_EDGES + 1);
   logic [N-1:0] prev_q, acc_q, acc_d;
   logic [CW-1:0] cnt_q;
   wire [N-1:0] edge_near = taps ^ {taps[N-2:0], taps[0]};
   wire [N-1:0] unstable = (cnt_q != '0) ? (taps ^ prev_q) : '0;
   wire [N-1:0] ends = {1'b1, {(N-2){1'b0}}, 1'b1};
   wire sat = (cnt_q == CW'(MIN_EDGES));

   // a bit turns one on a transition next to it or on jitter between edges
   assign acc_d = restart ? '0 : ref_rise ? (acc_q | edge_near | unstable) : acc_q;

   // ****************************************
   // accumulation
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
         acc_q <= '0;
         cnt_q <= '0;
         map <= '0;
         valid <= 1'b0;
      end else begin
         prev_q <= ref_rise ? taps : prev_q;
         acc_q <= acc_d;
         cnt_q <= restart ? '0 : (ref_rise && !sat) ? cnt_q + 1'b1 : cnt_q;
         map <= acc_d | ends; // edge positions always flagged
         valid <= !restart && (sat || (ref_rise && cnt_q == CW'(MIN_EDGES - 1)));
      end
   end

   initial begin
      if (N != MAP_W) $error("ref_position_detector: map must be 24 wide");
   end
endmodule : ref_position_detector

`default_nettype wire

/* verilog/sysref_window_and_autocal.sv */
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - map reports valid only after three reference rising edges were seen.
// - a map bit is one where capturing risks setup or hold violation.
// - 24 map bits over three byte registers, low address smallest delay.
// - selector takes only positions 0 to 15; higher map bits are information.
// - selector value is the binary index of the chosen map bit.
// - map bits 0 and 23 always read one.
// - zoom bit zero gives coarse steps, one gives fine steps.
// - configure first, then set enable; calibration starts on enable rising.
// - search delay until clock falling edge meets reference rising edge.
// - sweep coarse under both polarities, keep smallest coarse value.
// - done flag set when calibration finishes.
// - found inversion, coarse and fine delay readable afterwards.
// - found delay applied until controller disables and writes delay directly.
// - inversion adds half a clock period, independent of coarse and fine.
module sysref_window_and_autocal
   import ref_window_pkg::*;
#(
   parameter int DW = DLY_W
) (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog samplers, asynchronous
   input wire logic ref_in,
   input wire logic [MAP_W-1:0] tap_sample,
   input wire logic fall_after_ref,
   // delay line and capture controls
   output logic [SEL_W-1:0] ref_capture_instant_select,
   output logic ref_delay_step_fine,
   output logic aperture_clock_invert,
   output logic [DW-1:0] aperture_delay_coarse,
   output logic [DW-1:0] aperture_delay_fine
);

   // ****************************************
   // pin synchronisation
   // ****************************************
   logic ref_s, fall_s, ref_prev_q;
   logic [MAP_W-1:0] taps_s;

   signal_sync #(.W(MAP_W + 2)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({ref_in, fall_after_ref, tap_sample}),
      .q({ref_s, fall_s, taps_s})
   );

   wire ref_rise = ref_s && !ref_prev_q;

   // ****************************************
   // apb decode
   // ****************************************
   wire setup = psel && !penable;
   wire wr = psel && penable && pready && pwrite;
   wire hit_ctrl = paddr == reg_addr(IDX_CLK_CTRL);
   wire hit_en = paddr == reg_addr(IDX_CAL_EN);
   wire hit_cfg = paddr == reg_addr(IDX_CAL_CFG);
   wire hit_low = paddr == reg_addr(IDX_POS_LOW);
   wire hit_mid = paddr == reg_addr(IDX_POS_MID);
   wire hit_high = paddr == reg_addr(IDX_POS_HIGH);
   wire hit_stat = paddr == reg_addr(IDX_CAL_STAT);
   wire hit_found = paddr == reg_addr(IDX_FOUND);
   wire hit_tad = paddr == reg_addr(IDX_TAD);
   wire mapped = hit_ctrl || hit_en || hit_cfg || hit_low || hit_mid || hit_high
      || hit_stat || hit_found || hit_tad;

   // ****************************************
   // control registers
   // ****************************************
   logic [SEL_W-1:0] sel_q;
   logic zoom_q, en_q, en_prev_q, manual_q, done_q;
   logic [7:0] cfg_q;
   logic [TAD_W-1:0] tad_q, found_q;
   logic [MAP_W-1:0] map;
   logic map_valid;

   // only the low four bits land, positions 16 and up are unreachable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_q <= SEL_RST;
         zoom_q <= ZOOM_RST;
         en_q <= 1'b0;
         cfg_q <= CFG_RST;
         tad_q <= TAD_RST;
      end else begin
         if (wr && hit_ctrl) begin
            sel_q <= pwdata[CTRL_SEL_LSB +: SEL_W];
            zoom_q <= pwdata[CTRL_ZOOM_BIT];
         end
         if (wr && hit_en) en_q <= pwdata[EN_BIT];
         if (wr && hit_cfg) cfg_q <= pwdata[7:0];
         if (wr && hit_tad) tad_q <= pwdata[TAD_W-1:0];
      end
   end

   // a zoom change moves every tap, so the old map means nothing
   wire map_restart = wr && hit_ctrl && (pwdata[CTRL_ZOOM_BIT] != zoom_q);

   ref_position_detector #(.N(MAP_W)) u_detect (
      .clk(pclk),
      .rst_n(presetn),
      .ref_rise(ref_rise),
      .restart(map_restart),
      .taps(taps_s),
      .map(map),
      .valid(map_valid)
   );

   // ****************************************
   // autocal sequencer
   // ****************************************
   cal_state_t state_q, state_d;
   logic inv_q, inv_d, fine_ph_q, fine_ph_d;
   logic [DW-1:0] coarse_q, coarse_d, fine_q, fine_d, best_q, best_d;
   logic [7:0] ecnt_q, ecnt_d;
   logic [1:0] guard_q;

   localparam logic [DW-1:0] DMAX = '1;
   wire start = en_q && !en_prev_q;
   wire busy = state_q == CAL_SETTLE || state_q == CAL_JUDGE;
   // comparator lags a delay change by three cycles, earlier edges would judge stale phase
   wire settled = &guard_q;
   wire [7:0] settle_n = (cfg_q == 8'h00) ? 8'h01 : cfg_q;
   wire coarse_hit = fall_s || coarse_q == DMAX;
   wire fine_hit = fall_s || fine_q == DMAX;
   // polarity one wins only with a strictly smaller coarse value
   wire pick_inv = coarse_q < best_q;
   wire [DW-1:0] pick_c = pick_inv ? coarse_q : best_q;

   always_comb begin
      state_d = state_q;
      inv_d = inv_q;
      fine_ph_d = fine_ph_q;
      coarse_d = coarse_q;
      fine_d = fine_q;
      best_d = best_q;
      ecnt_d = ecnt_q;
      case (state_q)
         CAL_IDLE, CAL_DONE: begin
            if (start) begin
               state_d = CAL_SETTLE;
               inv_d = 1'b0;
               fine_ph_d = 1'b0;
               coarse_d = '0;
               fine_d = '0;
               ecnt_d = 8'h00;
            end
         end
         CAL_SETTLE: begin
            // wait for the delay line to settle over several reference edges
            if (ref_rise && settled) ecnt_d = ecnt_q + 8'h01;
            if (ref_rise && settled && ecnt_q + 8'h01 >= settle_n) state_d = CAL_JUDGE;
         end
         CAL_JUDGE: begin
            state_d = CAL_SETTLE;
            ecnt_d = 8'h00;
            if (!fine_ph_q && !coarse_hit) begin
               coarse_d = coarse_q + 1'b1;
            end else if (!fine_ph_q && !inv_q) begin
               best_d = coarse_q; // normal polarity done, try inverted
               inv_d = 1'b1;
               coarse_d = '0;
            end else if (!fine_ph_q) begin
               inv_d = pick_inv;
               coarse_d = (pick_c == '0) ? '0 : pick_c - 1'b1;
               fine_ph_d = 1'b1;
            end else if (!fine_hit) begin
               fine_d = fine_q + 1'b1;
            end else begin
               state_d = CAL_DONE;
            end
         end
         default: state_d = CAL_IDLE;
      endcase
      if (!en_q) state_d = (state_q == CAL_DONE) ? CAL_DONE : CAL_IDLE;
   end

   wire finish = state_q == CAL_JUDGE && state_d == CAL_DONE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CAL_IDLE;
         inv_q <= 1'b0;
         fine_ph_q <= 1'b0;
         coarse_q <= '0;
         fine_q <= '0;
         best_q <= '0;
         ecnt_q <= 8'h00;
         guard_q <= 2'h0;
         ref_prev_q <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         inv_q <= inv_d;
         fine_ph_q <= fine_ph_d;
         coarse_q <= coarse_d;
         fine_q <= fine_d;
         best_q <= best_d;
         ecnt_q <= ecnt_d;
         guard_q <= (state_q == CAL_SETTLE) ? guard_q + {1'b0, !settled} : 2'h0;
         ref_prev_q <= ref_s;
         en_prev_q <= en_q;
      end
   end

   // ****************************************
   // result, done flag and delay selection
   // ****************************************
   // set wins over the enable-edge clear, though finish needs enable high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
         found_q <= TAD_RST;
         manual_q <= 1'b0;
      end else begin
         done_q <= finish || (done_q && en_q == en_prev_q);
         found_q <= finish ? {inv_q, coarse_q, fine_q} : found_q;
         manual_q <= start ? 1'b0 : (wr && hit_tad && !en_q) ? 1'b1 : manual_q;
      end
   end

   // search setting while busy, then found result until a manual override
   wire [TAD_W-1:0] apply_d = busy ? {inv_q, coarse_q, fine_q}
      : manual_q ? tad_q : found_q;

   // ****************************************
   // apb read data and outputs
   // ****************************************
   wire [31:0] stat = {29'h0, busy, map_valid, done_q};
   wire [31:0] rdata = hit_ctrl ? {27'h0, zoom_q, sel_q}
      : hit_en ? {31'h0, en_q}
      : hit_cfg ? {24'h0, cfg_q}
      : hit_low ? {24'h0, map[7:0]}
      : hit_mid ? {24'h0, map[15:8]}
      : hit_high ? {24'h0, map[23:16]}
      : hit_stat ? stat
      : hit_found ? {15'h0, found_q}
      : hit_tad ? {15'h0, tad_q}
      : 32'h0;

   // read data and error latched in the setup cycle, zero-wait access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ref_capture_instant_select <= SEL_RST;
         ref_delay_step_fine <= ZOOM_RST;
         aperture_clock_invert <= 1'b0;
         aperture_delay_coarse <= '0;
         aperture_delay_fine <= '0;
      end else begin
         prdata <= setup ? rdata : prdata;
         pready <= 1'b1;
         pslverr <= setup ? !mapped : pslverr;
         ref_capture_instant_select <= sel_q;
         ref_delay_step_fine <= zoom_q;
         aperture_clock_invert <= apply_d[APERTURE_CLOCK_INVERT_BIT];
         aperture_delay_coarse <= apply_d[APERTURE_DELAY_COARSE_LSB +: DW];
         aperture_delay_fine <= apply_d[APERTURE_DELAY_FINE_LSB +: DW];
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [1:0] seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) seen_q <= 2'h0;
      else if (map_restart) seen_q <= 2'h0;
      else if (ref_rise && seen_q != 2'h3) seen_q <= seen_q + 2'h1;
   end

   a_map_valid_edges: assert property (map_valid |-> seen_q == 2'h3)
      else $error("map valid before three reference edges");
   a_map_ends_set: assert property (map_valid |-> map[0] && map[MAP_W-1])
      else $error("map end bits not set");
   a_sel_write: assert property (wr && hit_ctrl |=> ##1
      ref_capture_instant_select == $past(pwdata[3:0], 2))
      else $error("selector does not follow written index");
   a_zoom_write: assert property (wr && hit_ctrl |=> ##1
      ref_delay_step_fine == $past(pwdata[4], 2))
      else $error("zoom output does not follow register");
   a_cal_start: assert property (start && state_q != CAL_SETTLE |=>
      state_q == CAL_SETTLE && !inv_q && coarse_q == '0)
      else $error("calibration did not start from zero");
   a_both_polarities: assert property ($rose(fine_ph_q) |-> $past(inv_q))
      else $error("fine phase entered before inverted sweep");
   a_done_result: assert property ($rose(done_q) |=>
      {aperture_clock_invert, aperture_delay_coarse, aperture_delay_fine} == found_q)
      else $error("found delay not applied at done");
   a_done_clear: assert property (en_q != en_prev_q && !finish |=> !done_q)
      else $error("done not cleared on enable change");
   a_manual_apply: assert property (manual_q && !busy |=>
      aperture_delay_coarse == $past(tad_q[APERTURE_DELAY_COARSE_LSB +: DW]))
      else $error("manual delay not applied");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not flagged");

   c_cal_done: cover property ($rose(done_q));
   c_map_valid: cover property ($rose(map_valid));
   c_inv_chosen: cover property (finish && inv_q);
   c_manual_mode: cover property ($rose(manual_q));

   initial begin
      if (DW != DLY_W) $error("delay width must be 8");
   end
endmodule : sysref_window_and_autocal

`default_nettype wire

/* testbench/ref_clock_source.sv */
`timescale 1ns/10ps
`default_nettype none

// far-side clock source: periodic reference, tap snapshots, phase comparator
module ref_clock_source #(
   parameter int PER = 16,
   parameter int STEP = 4,
   parameter int HALF = 40
) (
   // clock
   input wire logic pclk,
   // bench controls
   input wire logic run,
   input wire logic [4:0] pos,
   input wire logic [9:0] tgt,
   // delay applied by the device
   input wire logic inv,
   input wire logic [7:0] coarse,
   input wire logic [7:0] fine,
   // toward the device, and the rise count for the bench
   output logic ref_in,
   output logic [23:0] taps,
   output logic fall_after_ref,
   output int rises
);
   int phase;

   initial begin
      phase = 0;
      rises = 0;
      ref_in = 1'b0;
   end

   // square reference, parked low while stopped so no stray edge appears
   always @(posedge pclk) begin
      if (!run) begin
         phase <= 0;
         ref_in <= 1'b0;
      end else begin
         phase <= (phase + 1) % PER;
         ref_in <= (phase < PER / 2);
         if (phase == 0) begin
            rises <= rises + 1;
         end
      end
   end

   // instants at or after the edge see the reference high
   assign taps = 24'hFFFFFF << pos;

   // inversion adds half a period on top of coarse and fine
   assign fall_after_ref =
      (int'(inv) * HALF + int'(coarse) * STEP + int'(fine)) >= int'(tgt);

endmodule : ref_clock_source

`default_nettype wire

/* testbench/sysref_window_and_autocal_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module sysref_window_and_autocal_tb
   import ref_window_pkg::*;
;
   localparam int HALF = 40;
   localparam int STEP = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ref_in;
   logic [MAP_W-1:0] taps;
   logic cmp;
   logic [SEL_W-1:0] sel_out;
   logic fine_step;
   logic inv;
   logic [7:0] coarse;
   logic [7:0] fine;
   logic run = 1'b0;
   logic [4:0] pos = 5'h00;
   logic [9:0] tgt = 10'h000;
   logic zoom = 1'b0;
   logic [31:0] seed = 32'hEADB;
   logic [31:0] rd;
   logic err;
   int rises;
   int failures = 0;
   int comparisons = 0;

   initial begin
      forever #2 pclk = ~pclk;
   end

   sysref_window_and_autocal #(.DW(8)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_in(ref_in), .tap_sample(taps), .fall_after_ref(cmp),
      .ref_capture_instant_select(sel_out), .ref_delay_step_fine(fine_step),
      .aperture_clock_invert(inv), .aperture_delay_coarse(coarse), .aperture_delay_fine(fine)
   );

   ref_clock_source #(.PER(16), .STEP(STEP), .HALF(HALF)) src_u (
      .pclk(pclk), .run(run), .pos(pos), .tgt(tgt), .inv(inv), .coarse(coarse),
      .fine(fine), .ref_in(ref_in), .taps(taps), .fall_after_ref(cmp), .rises(rises)
   );

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   // one transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wait_rises(input int n);
      for (int i = 0; i < 2000 && rises < n; i++) begin
         @(posedge pclk);
      end
      if (rises < n) failures++;
   endtask : wait_rises

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction : lfsr

   function automatic logic meets(input int i, input int c, input int f, input int t);
      return (i * HALF + c * STEP + f) >= t;
   endfunction : meets

   // search outcome: smallest coarse over both polarities, then fine from one below
   function automatic logic [16:0] exp_found(input int t);
      int c[2];
      int p;
      int f;
      int v;
      for (v = 0; v < 2; v++) begin
         c[v] = 0;
         while (c[v] < 255 && !meets(v, c[v], 0, t))
            c[v]++;
      end
      v = (c[1] < c[0]) ? 1 : 0;
      p = (c[v] > 0) ? c[v] - 1 : 0;
      f = 0;
      while (f < 255 && !meets(v, p, f, t))
         f++;
      return {v[0], p[7:0], f[7:0]};
   endfunction : exp_found

   // ****************************************
   // scenarios
   // ****************************************
   // zoom toggle restarts the map; slow clock here, so zoom only serves as restart
   task automatic map_case(input int k);
      logic [23:0] m;
      int r0;
      m = 24'h800001 | (24'h000001 << k);
      pos <= k[4:0];
      run <= 1'b1;
      wait_rises(rises + 2);
      run <= 1'b0;
      zoom = ~zoom;
      apb(1'b1, IDX_CLK_CTRL, {27'h0, zoom, 4'h0});
      repeat (2) @(posedge pclk);
      check(fine_step, zoom);
      r0 = rises;
      run <= 1'b1;
      wait_rises(r0 + 2);
      repeat (8) @(posedge pclk);
      apb(1'b0, IDX_CAL_STAT, 32'h0);
      check(rd[STAT_VALID_BIT], 1'b0);
      wait_rises(r0 + 3);
      repeat (8) @(posedge pclk);
      apb(1'b0, IDX_CAL_STAT, 32'h0);
      check(rd[STAT_VALID_BIT], 1'b1);
      apb(1'b1, IDX_POS_LOW, {24'h0, ~m[7:0]});
      apb(1'b0, IDX_POS_LOW, 32'h0);
      check(rd, {24'h0, m[7:0]});
      apb(1'b0, IDX_POS_MID, 32'h0);
      check(rd, {24'h0, m[15:8]});
      apb(1'b0, IDX_POS_HIGH, 32'h0);
      check(rd, {24'h0, m[23:16]});
   endtask : map_case

   // clock running and registers configured in the transfer just before enabling
   task automatic cal_case(input int t, input logic [7:0] cfg);
      logic [16:0] e;
      int n;
      e = exp_found(t);
      tgt <= t[9:0];
      run <= 1'b1; // reference stays periodic throughout
      apb(1'b1, IDX_CAL_CFG, {24'h0, cfg}); // configuration before enable
      apb(1'b1, IDX_CAL_EN, 32'h1);
      apb(1'b0, IDX_CAL_STAT, 32'h0);
      check({rd[STAT_BUSY_BIT], rd[STAT_DONE_BIT]}, 2'b10);
      for (n = 0; n < 3000 && rd[STAT_DONE_BIT] !== 1'b1; n++) begin
         apb(1'b0, IDX_CAL_STAT, 32'h0);
      end
      check(rd[STAT_DONE_BIT], 1'b1);
      apb(1'b0, IDX_FOUND, 32'h0);
      check(rd, {15'h0, e});
      repeat (2) @(posedge pclk);
      check({inv, coarse, fine}, e);
      // no converter calibration sits beside this block to pause
      apb(1'b1, IDX_CAL_EN, 32'h0);
      apb(1'b0, IDX_CAL_STAT, 32'h0);
      check(rd[STAT_DONE_BIT], 1'b0);
      check({inv, coarse, fine}, e);
      seed = lfsr(seed);
      apb(1'b1, IDX_TAD, {15'h0, seed[16:0]}); // stored delay, calibration off
      repeat (2) @(posedge pclk);
      check({inv, coarse, fine}, seed[16:0]);
   endtask : cal_case

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IDX_CAL_CFG, 32'h0);
      check(rd, {24'h0, CFG_RST});
      apb(1'b0, IDX_CAL_STAT, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, IDX_FOUND, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      // every selector index, read back and on the port; middle picks left to software
      for (int s = 0; s < 16; s++) begin
         apb(1'b1, IDX_CLK_CTRL, 32'(s));
         repeat (2) @(posedge pclk);
         check(sel_out, s[3:0]);
         apb(1'b0, IDX_CLK_CTRL, 32'h0);
         check(rd, 32'(s));
      end
      apb(1'b1, IDX_CLK_CTRL, 32'h0); // selector zero before autocal
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         map_case((i < 6) ? (i * 5 - (i > 4 ? 2 : 0)) : int'(seed % 24));
      end
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         cal_case((i < 3) ? i * 41 + (i > 1 ? 45 : 0) : int'(seed % 128),
                  (i == 0) ? 8'h00 : 8'(seed[3:2] + 1));
      end
      conclude();
   end

   // hang guard well beyond the longest expected run
   initial begin
      repeat (90000) @(posedge pclk);
      failures++;
      conclude();
   end

endmodule : sysref_window_and_autocal_tb

`default_nettype wire
